// File: verilog/csc_pkg.sv
// Package: register map, field positions and event carriers for status capture
package csc_pkg;

    // Register byte offsets
    localparam logic [7:0] REG_PARITY     = 8'h00;
    localparam logic [7:0] REG_CAUSE_HI   = 8'h04;
    localparam logic [7:0] REG_CAUSE      = 8'h08;
    localparam logic [7:0] REG_FAIL_ADDR  = 8'h0C;
    localparam logic [7:0] REG_FAIL_PC    = 8'h10;
    localparam logic [7:0] REG_CONTROL    = 8'h14;
    localparam logic [7:0] REG_MIRROR     = 8'h18;

    // Control register fields
    localparam int CTL_CLEAR  = 0;
    localparam int CTL_MODE_LO = 1;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

    // Bit n (1 = MSB) maps to index 32-n
    function automatic int bitpos(input int n);
        return 32 - n;
    endfunction

    // Check kinds
    typedef enum logic [2:0] {
        CSC_NONE    = 3'b000,
        CSC_CECC    = 3'b001,
        CSC_MCHK    = 3'b010,
        CSC_UECC    = 3'b011,
        CSC_MISSING = 3'b100,
        CSC_POWER   = 3'b101
    } csc_kind_t;

    // Per-event hardware cause indications
    typedef struct packed {
        logic       dmt_cycle_err;
        logic       arith_board_err;
        logic       cache_board_err;
        logic       mdb_even_err;
        logic       mdb_odd_err;
        logic       miss_no_module;
        logic       mab_parity_err;
        logic       mar_incremented;
        logic       addr_ind_a;
        logic       addr_ind_b;
        logic       uecc_err;
        logic       cecc_err;
        logic       cache_index_err;
        logic       cache_odd_err;
        logic       cache_even_err;
        logic       cycle_execute;
    } csc_parity_t;

    typedef struct packed {
        logic       immediate;
        logic       mem_parity;
        logic [3:0] unit_flags;    // ext, storage, instr, memctl
        logic       cs_board;
        logic       rom_parity;
        logic [2:0] backup_count;
        logic       backup_invalid;
        logic       dmt_active;
        logic       io_active;
        logic [6:0] syndrome;
        logic [2:0] mchk_code;
        logic       verify_pass;
        logic [5:0] verify_test;
    } csc_cause_t;

    typedef struct packed {
        logic        valid;
        csc_kind_t   kind;
        logic [22:0] phys_addr;
        logic [31:0] prog_cnt;
        csc_parity_t par;
        csc_cause_t  cause;
    } csc_event_t;

endpackage

// File: verilog/csc_capture.sv
// Diagnostic status word capture with APB register access
//
// Contract
// - Parity bits 15-17 for transfer/board errors
// - Bits 18-19 for memory data bus
// - Bits 20-21 missing module, address parity
// - Bits 22-24 increment and indicator states
// - Bits 25-26 uncorrectable and correctable ECC
// - Bits 27-29 cache index and data parity
// - Bit 30 cycle purpose; 31-32 unused
// - Cause bits 1-4 immediate, machine, parity, missing
// - High-end bits 5-8, 11, 12 unit flags
// - Bits 9-10 qualify ECC kind
// - Backup count fields per variant, invalid bit
// - Bits 15-16 transfer and I/O active
// - Syndrome in bits 17-23 or 17-22
// - Bit 24 module from address bit 15
// - Bit 25 flags invalid failing address
// - Machine check code bits 5-7, bit 8
// - Self-verify pass and test per variant
// - Failing address valid only ECC/missing
// - Address priority missing, machine/UECC, CECC
// - Program counter priority, always valid
// - Mirror copy on every non-power check
// - Report mode from two-bit modals field
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps

module csc_capture (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic                mid_range,
    input  wire csc_pkg::csc_event_t chk_event,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic      [1:0]          check_report_mode,
    output logic                     mirror_we,
    output logic      [2:0]          mirror_index,
    output logic      [31:0]         mirror_data
);

    logic [31:0] parity_r;
    logic [31:0] cause_hi_r;
    logic [31:0] cause_r;
    logic [31:0] fail_addr_r;
    logic [31:0] fail_pc_r;
    logic [2:0]  held_kind_r;
    logic        mirror_busy_r;
    logic [2:0]  mirror_sel;
    logic [31:0] parity_nxt;
    logic [31:0] cause_hi_nxt;
    logic [31:0] cause_nxt;
    logic        take_addr;
    logic        addr_valid;
    logic        evt_sets;
    logic        acc_w;
    logic        sw_clear;

    // Priority rank of a check kind for address and counter holding
    function automatic logic [1:0] rank(input logic [2:0] k);
        unique case (k)
            3'(csc_pkg::CSC_MISSING): rank = 2'h3;
            3'(csc_pkg::CSC_MCHK),
            3'(csc_pkg::CSC_UECC):    rank = 2'h2;
            3'(csc_pkg::CSC_CECC):    rank = 2'h1;
            default:                  rank = 2'h0;
        endcase
    endfunction

    // Power failure does not touch the status word
    assign evt_sets = chk_event.valid &&
                      (chk_event.kind != csc_pkg::CSC_POWER) &&
                      (chk_event.kind != csc_pkg::CSC_NONE);
    assign acc_w    = psel && penable && pwrite;
    assign sw_clear = acc_w && (paddr == csc_pkg::REG_CONTROL) &&
                      pwdata[csc_pkg::CTL_CLEAR];

    assign addr_valid = (chk_event.kind == csc_pkg::CSC_CECC) ||
                        (chk_event.kind == csc_pkg::CSC_UECC) ||
                        (chk_event.kind == csc_pkg::CSC_MISSING);
    // priority rank keeps the stronger check
    assign take_addr  = evt_sets &&
                        (rank(3'(chk_event.kind)) >= rank(held_kind_r));

    // bit numbers through bitpos, MSB first
    always_comb begin
        parity_nxt = RESET_ZERO_W();
        parity_nxt[csc_pkg::bitpos(15)] = chk_event.par.dmt_cycle_err;
        parity_nxt[csc_pkg::bitpos(16)] = chk_event.par.arith_board_err;
        parity_nxt[csc_pkg::bitpos(17)] = chk_event.par.cache_board_err;
        parity_nxt[csc_pkg::bitpos(18)] = chk_event.par.mdb_even_err;
        parity_nxt[csc_pkg::bitpos(19)] = chk_event.par.mdb_odd_err;
        parity_nxt[csc_pkg::bitpos(20)] = chk_event.par.miss_no_module;
        parity_nxt[csc_pkg::bitpos(21)] = chk_event.par.mab_parity_err;
        parity_nxt[csc_pkg::bitpos(22)] = chk_event.par.mar_incremented;
        parity_nxt[csc_pkg::bitpos(23)] = chk_event.par.addr_ind_a;
        parity_nxt[csc_pkg::bitpos(24)] = chk_event.par.addr_ind_b;
        parity_nxt[csc_pkg::bitpos(25)] = chk_event.par.uecc_err;
        parity_nxt[csc_pkg::bitpos(26)] = chk_event.par.cecc_err;
        parity_nxt[csc_pkg::bitpos(27)] = chk_event.par.cache_index_err;
        parity_nxt[csc_pkg::bitpos(28)] = chk_event.par.cache_odd_err;
        parity_nxt[csc_pkg::bitpos(29)] = chk_event.par.cache_even_err;
        // cycle purpose, bits 31-32 left zero
        parity_nxt[csc_pkg::bitpos(30)] = chk_event.par.cycle_execute;
    end

    function automatic logic [31:0] RESET_ZERO_W();
        return csc_pkg::RESET_ZERO;
    endfunction

    // Common cause fields shared by both variants
    always_comb begin
        cause_nxt    = RESET_ZERO_W();
        cause_hi_nxt = RESET_ZERO_W();
        cause_nxt[csc_pkg::bitpos(1)] = chk_event.cause.immediate;
        cause_nxt[csc_pkg::bitpos(2)] =
            (chk_event.kind == csc_pkg::CSC_MCHK);
        cause_nxt[csc_pkg::bitpos(3)] = chk_event.cause.mem_parity;
        cause_nxt[csc_pkg::bitpos(4)] =
            (chk_event.kind == csc_pkg::CSC_MISSING);
        cause_nxt[csc_pkg::bitpos(9)]  =
            (chk_event.kind == csc_pkg::CSC_UECC);
        cause_nxt[csc_pkg::bitpos(10)] =
            (chk_event.kind == csc_pkg::CSC_CECC);
        cause_nxt[csc_pkg::bitpos(15)] = chk_event.cause.dmt_active;
        cause_nxt[csc_pkg::bitpos(16)] = chk_event.cause.io_active;
        // interleave module from address bit 15
        cause_nxt[csc_pkg::bitpos(24)] = chk_event.phys_addr[15];
        cause_nxt[csc_pkg::bitpos(25)] = !addr_valid;
        cause_hi_nxt = cause_nxt;
        cause_hi_nxt[csc_pkg::bitpos(5):csc_pkg::bitpos(8)] =
            chk_event.cause.unit_flags;
        cause_hi_nxt[csc_pkg::bitpos(11)] = chk_event.cause.cs_board;
        cause_hi_nxt[csc_pkg::bitpos(12)] = chk_event.cause.rom_parity;
        // two-bit backup count on high end
        cause_hi_nxt[csc_pkg::bitpos(13):csc_pkg::bitpos(14)] =
            chk_event.cause.backup_count[1:0];
        cause_hi_nxt[csc_pkg::bitpos(17):csc_pkg::bitpos(23)] =
            chk_event.cause.syndrome;
        // machine check code; bit 8 cleared on detection
        cause_nxt[csc_pkg::bitpos(5):csc_pkg::bitpos(7)] =
            chk_event.cause.mchk_code;
        cause_nxt[csc_pkg::bitpos(8)] = 1'b0;
        cause_nxt[csc_pkg::bitpos(11)] = chk_event.cause.backup_invalid;
        cause_nxt[csc_pkg::bitpos(12):csc_pkg::bitpos(14)] =
            chk_event.cause.backup_count;
        cause_nxt[csc_pkg::bitpos(17):csc_pkg::bitpos(22)] =
            chk_event.cause.syndrome[5:0];
        if (mid_range) begin
            cause_nxt[csc_pkg::bitpos(26)] = chk_event.cause.verify_pass;
            cause_nxt[csc_pkg::bitpos(27):csc_pkg::bitpos(32)] =
                chk_event.cause.verify_test;
        end else begin
            cause_nxt[csc_pkg::bitpos(27)] = chk_event.cause.verify_pass;
            cause_nxt[csc_pkg::bitpos(28):csc_pkg::bitpos(32)] =
                chk_event.cause.verify_test[4:0];
        end
    end

    // Parity accumulates over checks, cause words hold the latest; a clear with an event leaves only the new parity bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parity_r   <= csc_pkg::RESET_ZERO;
            cause_hi_r <= csc_pkg::RESET_ZERO;
            cause_r    <= csc_pkg::RESET_ZERO;
        end else if (evt_sets) begin
            parity_r   <= (sw_clear ? csc_pkg::RESET_ZERO : parity_r)
                          | parity_nxt;
            cause_hi_r <= cause_hi_nxt;
            cause_r    <= cause_nxt;
        end else if (sw_clear) begin
            parity_r   <= csc_pkg::RESET_ZERO;
            cause_hi_r <= csc_pkg::RESET_ZERO;
            cause_r    <= csc_pkg::RESET_ZERO;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_addr_r <= csc_pkg::RESET_ZERO;
            fail_pc_r   <= csc_pkg::RESET_ZERO;
            held_kind_r <= 3'h0;
        end else if (take_addr) begin
            fail_addr_r <= {9'h000, chk_event.phys_addr};
            // counter always captured with same priority
            fail_pc_r   <= chk_event.prog_cnt;
            held_kind_r <= 3'(chk_event.kind);
        end else if (sw_clear) begin
            held_kind_r <= 3'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            check_report_mode <= 2'h0;
        end else if (acc_w && (paddr == csc_pkg::REG_CONTROL)) begin
            check_report_mode <=
                pwdata[csc_pkg::CTL_MODE_LO +: 2];
        end
    end

    // Word shown next, so data lines up with the index beside it
    assign mirror_sel = mirror_we ? mirror_index + 3'h1 : mirror_index;

    // mirror sweep of the four words after each non-power check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mirror_busy_r <= 1'b0;
            mirror_index  <= 3'h0;
            mirror_we     <= 1'b0;
            mirror_data   <= csc_pkg::RESET_ZERO;
        end else if (evt_sets) begin
            mirror_busy_r <= 1'b1;
            mirror_index  <= 3'h0;
            mirror_we     <= 1'b0;
        end else if (mirror_busy_r) begin
            mirror_we <= 1'b1;
            unique case (mirror_sel)
                3'h0:    mirror_data <= parity_r;
                3'h1:    mirror_data <= mid_range ? cause_r : cause_hi_r;
                3'h2:    mirror_data <= fail_addr_r;
                default: mirror_data <= fail_pc_r;
            endcase
            if (mirror_we) begin
                mirror_index <= mirror_sel;
            end
            if (mirror_we && (mirror_index == 3'h3)) begin
                mirror_busy_r <= 1'b0;
                mirror_we     <= 1'b0;
            end
        end else begin
            mirror_we <= 1'b0;
        end
    end

    // APB read; zero wait states, unmapped reads error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= csc_pkg::RESET_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= csc_pkg::RESET_ZERO;
            if (psel && !penable) begin
                unique case (paddr)
                    csc_pkg::REG_PARITY:    prdata <= parity_r;
                    csc_pkg::REG_CAUSE_HI:  prdata <= cause_hi_r;
                    csc_pkg::REG_CAUSE:     prdata <= cause_r;
                    csc_pkg::REG_FAIL_ADDR: prdata <= fail_addr_r;
                    csc_pkg::REG_FAIL_PC:   prdata <= fail_pc_r;
                    csc_pkg::REG_CONTROL:
                        prdata <= {29'h0000_0000, check_report_mode, 1'b0};
                    csc_pkg::REG_MIRROR:
                        prdata <= {28'h000_0000, mirror_busy_r, mirror_index};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Helper: cycles the mirror has been busy
    logic [3:0] busy_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt <= 4'h0;
        end else begin
            busy_cnt <= (mirror_busy_r && !evt_sets) ?
                        busy_cnt + 4'h1 : 4'h0;
        end
    end

    default clocking dflt_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_event;
        evt_sets;
    endsequence

    unc_flag_a: assert property (
        (evt_sets && chk_event.kind == csc_pkg::CSC_UECC) |=>
        cause_r[csc_pkg::bitpos(9)])
        else $error("uncorrectable qualifier not set");
    miss_bit_a: assert property (
        (evt_sets && chk_event.kind == csc_pkg::CSC_MISSING) |=>
        cause_r[csc_pkg::bitpos(4)] && !cause_r[csc_pkg::bitpos(25)])
        else $error("missing module flags wrong");
    addr_inval_a: assert property (
        (evt_sets && chk_event.kind == csc_pkg::CSC_MCHK) |=>
        cause_r[csc_pkg::bitpos(25)])
        else $error("invalid address flag missing");
    prio_keep_a: assert property (
        (held_kind_r == 3'(csc_pkg::CSC_MISSING) && evt_sets &&
         chk_event.kind != csc_pkg::CSC_MISSING) |=>
        $stable(fail_addr_r) && $stable(fail_pc_r))
        else $error("lower check overwrote address");
    pc_take_a: assert property (
        (evt_sets && held_kind_r == 3'h0) |=>
        fail_pc_r == $past(chk_event.prog_cnt))
        else $error("program counter not captured");
    mdb_even_a: assert property (
        (evt_sets && chk_event.par.mdb_even_err) |=>
        parity_r[csc_pkg::bitpos(18)])
        else $error("even word parity bit lost");
    unused_low_a: assert property (
        parity_r[1:0] == 2'h0)
        else $error("unused parity bits set");
    mirror_run_a: assert property (
        s_event ##1 (!evt_sets)[*2] |-> mirror_busy_r && mirror_we)
        else $error("mirror sweep did not start");
    mirror_end_a: assert property (
        busy_cnt <= 4'h9)
        else $error("mirror sweep too long");
    mode_wr_a: assert property (
        (acc_w && paddr == csc_pkg::REG_CONTROL) |=>
        check_report_mode == $past(pwdata[2:1]))
        else $error("report mode not written");
    module_bit_a: assert property (
        evt_sets |=> cause_r[csc_pkg::bitpos(24)] ==
        $past(chk_event.phys_addr[15]))
        else $error("module bit mismatch");

endmodule

// File: test/check_status_capture_bench.sv
// Self-checking bench for the diagnostic status capture block
`timescale 1ns/100ps

module check_status_capture_bench;
    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata;
    logic                mid_range;
    csc_pkg::csc_event_t chk_event;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic [1:0]          check_report_mode;
    logic                mirror_we;
    logic [2:0]          mirror_index;
    logic [31:0]         mirror_data;
    int                  fails;
    int                  samples_checked;
    logic [31:0]         rd;
    logic                err;
    logic [31:0]         mir [4];
    int                  mir_n;

    csc_capture u_dut (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .mid_range         (mid_range),
        .chk_event         (chk_event),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .check_report_mode (check_report_mode),
        .mirror_we         (mirror_we),
        .mirror_index      (mirror_index),
        .mirror_data       (mirror_data)
    );

    always #2.5 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic end_of_test();
        $display("checked=%0d mismatches=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Waits on pready, never on a fixed count
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(32'(n), 32'd1, "wait states");
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Mixed cause pattern so every field has a distinct value
    function automatic csc_pkg::csc_event_t mk(input csc_pkg::csc_kind_t k,
        input logic [22:0] a, input logic [31:0] pc, input logic [15:0] p);
        csc_pkg::csc_event_t e;
        e = '0;
        e.valid = 1'b1;
        e.kind = k;
        e.phys_addr = a;
        e.prog_cnt = pc;
        e.par = csc_pkg::csc_parity_t'(p);
        e.cause = csc_pkg::csc_cause_t'(31'h755C_AF6D);
        return e;
    endfunction

    // Addresses are picked with bit 15 equal to bit 8
    function automatic logic [31:0] cause_exp(input csc_pkg::csc_event_t e,
                                              input logic hi,
                                              input logic mid);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[31] = e.cause.immediate;
        v[30] = e.kind == csc_pkg::CSC_MCHK;
        v[29] = e.cause.mem_parity;
        v[28] = e.kind == csc_pkg::CSC_MISSING;
        v[23] = e.kind == csc_pkg::CSC_UECC;
        v[22] = e.kind == csc_pkg::CSC_CECC;
        v[17] = e.cause.dmt_active;
        v[16] = e.cause.io_active;
        v[8]  = e.phys_addr[15];
        v[7]  = !(e.kind inside {csc_pkg::CSC_CECC, csc_pkg::CSC_UECC,
                                 csc_pkg::CSC_MISSING});
        if (hi) begin
            v[27:24] = e.cause.unit_flags;
            v[21]    = e.cause.cs_board;
            v[20]    = e.cause.rom_parity;
            v[19:18] = e.cause.backup_count[1:0];
            v[15:9]  = e.cause.syndrome;
        end else begin
            v[27:25] = e.cause.mchk_code;
            v[21]    = e.cause.backup_invalid;
            v[20:18] = e.cause.backup_count;
            v[15:10] = e.cause.syndrome[5:0];
            if (mid) begin
                v[6]   = e.cause.verify_pass;
                v[5:0] = e.cause.verify_test;
            end else begin
                v[5]   = e.cause.verify_pass;
                v[4:0] = e.cause.verify_test[4:0];
            end
        end
        return v;
    endfunction

    // Pulses one event and records the mirror sweep that follows
    task automatic fire(input csc_pkg::csc_event_t e, input logic mid);
        mir_n = 0;
        @(posedge pclk);
        chk_event <= e;
        mid_range <= mid;
        @(posedge pclk);
        chk_event.valid <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            @(negedge pclk);
            if (mirror_we === 1'b1) begin
                chk({29'h0, mirror_index}, 32'(mir_n), "mirror idx");
                if (mir_n < 4) mir[mir_n] = mirror_data;
                mir_n++;
            end
        end
    endtask

    task automatic check_state(input logic [15:0] p,
                               input csc_pkg::csc_event_t e, input logic mid,
                               input logic [22:0] a, input logic [31:0] pc);
        logic [31:0] lo;
        lo = cause_exp(e, 1'b0, mid);
        apb(1'b0, csc_pkg::REG_PARITY, 32'h0);
        chk(rd, {14'h0, p, 2'b00}, "parity");
        chk({31'h0, err}, 32'h0, "slverr");
        apb(1'b0, csc_pkg::REG_CAUSE_HI, 32'h0);
        chk(rd, cause_exp(e, 1'b1, mid), "cause hi");
        apb(1'b0, csc_pkg::REG_CAUSE, 32'h0);
        chk(rd, lo, "cause");
        apb(1'b0, csc_pkg::REG_FAIL_ADDR, 32'h0);
        chk(rd, {9'h0, a}, "fail addr");
        apb(1'b0, csc_pkg::REG_FAIL_PC, 32'h0);
        chk(rd, pc, "fail pc");
        chk(32'(mir_n), 32'd4, "mirror count");
        chk(mir[0], {14'h0, p, 2'b00}, "mirror parity");
        chk(mir[1], mid ? lo : cause_exp(e, 1'b1, mid), "mirror cause");
        chk(mir[2], {9'h0, a}, "mirror addr");
        chk(mir[3], pc, "mirror pc");
    endtask

    task automatic t_reset();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, csc_pkg::RESET_ZERO, "reset value");
            chk({31'h0, err}, 32'h0, "reset slverr");
        end
        apb(1'b1, csc_pkg::REG_PARITY, 32'hFFFF_FFFF);
        apb(1'b0, csc_pkg::REG_PARITY, 32'h0);
        chk(rd, 32'h0000_0000, "read-only write");
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped slverr");
        chk({30'h0, check_report_mode}, 32'h0, "mode at reset");
        $display("test reset done");
    endtask

    // Rank order: missing over machine/uncorrectable over correctable
    task automatic t_capture();
        csc_pkg::csc_event_t e1;
        csc_pkg::csc_event_t e2;
        csc_pkg::csc_event_t e3;
        csc_pkg::csc_event_t e4;
        e1 = mk(csc_pkg::CSC_UECC, 23'h4_8123, 32'h1234_5678, 16'hA5C3);
        e2 = mk(csc_pkg::CSC_CECC, 23'h1_0042, 32'h0BAD_F00D, 16'h5A3C);
        e3 = mk(csc_pkg::CSC_MISSING, 23'h7_C1FF, 32'h0000_ABCD, 16'h0001);
        e4 = mk(csc_pkg::CSC_MCHK, 23'h0_3000, 32'h7777_0001, 16'h0000);
        fire(e1, 1'b1);
        check_state(16'hA5C3, e1, 1'b1, 23'h4_8123, 32'h1234_5678);
        fire(e2, 1'b0);
        check_state(16'hFFFF, e2, 1'b0, 23'h4_8123, 32'h1234_5678);
        fire(e3, 1'b1);
        check_state(16'hFFFF, e3, 1'b1, 23'h7_C1FF, 32'h0000_ABCD);
        fire(e4, 1'b0);
        check_state(16'hFFFF, e4, 1'b0, 23'h7_C1FF, 32'h0000_ABCD);
        $display("test capture done");
    endtask

    task automatic t_clear_power();
        csc_pkg::csc_event_t e;
        e = mk(csc_pkg::CSC_CECC, 23'h1_0042, 32'h0BAD_F00D, 16'h0810);
        apb(1'b1, csc_pkg::REG_CONTROL, 32'h0000_0001);
        apb(1'b0, csc_pkg::REG_PARITY, 32'h0);
        chk(rd, 32'h0000_0000, "parity cleared");
        apb(1'b0, csc_pkg::REG_CAUSE, 32'h0);
        chk(rd, 32'h0000_0000, "cause cleared");
        fire(e, 1'b1);
        check_state(16'h0810, e, 1'b1, 23'h1_0042, 32'h0BAD_F00D);
        fire(mk(csc_pkg::CSC_POWER, 23'h7_FFFF, 32'h5555_5555, 16'hFFFF),
             1'b1);
        chk(32'(mir_n), 32'd0, "power mirror");
        apb(1'b0, csc_pkg::REG_PARITY, 32'h0);
        chk(rd, {14'h0, 16'h0810, 2'b00}, "power parity");
        apb(1'b0, csc_pkg::REG_FAIL_ADDR, 32'h0);
        chk(rd, {9'h0, 23'h1_0042}, "power addr");
        $display("test clear and power done");
    endtask

    task automatic t_mode();
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, csc_pkg::REG_CONTROL, {29'h0, 2'(m), 1'b0});
            @(negedge pclk);
            chk({30'h0, check_report_mode}, 32'(m), "report mode");
        end
        $display("test report mode done");
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        mid_range = 1'b0;
        chk_event = '0;
        fails = 0;
        samples_checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_capture();
        t_clear_power();
        t_mode();
        end_of_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #40000;
        fails++;
        end_of_test();
    end
endmodule
